// ### include/rsr_pkg.sv
// Purpose: shared constants for the run/stop/reset control block
// Assumes: 32-bit APB register word, 20 MHz system clock
// Notes:   offsets are byte addresses, one aligned word each
package rsr_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS         = 1000000;
  localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_KEY    = 8'h04;
  localparam logic [7:0] ADDR_DELAY  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  // control fields
  localparam int CTRL_LEVEL     = 0;
  localparam int CTRL_SRC_TERM  = 1;
  localparam int CTRL_SRC_KEY   = 2;
  localparam int CTRL_LOCAL     = 3;
  localparam int CTRL_RLY_MAN   = 4;
  localparam int CTRL_RLY_RETRY = 5;
  localparam int CTRL_COAST     = 6;
  localparam int CTRL_AUX_LO    = 8;
  localparam int CTRL_MAX_LO    = 12;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0006;
  localparam logic [31:0] CTRL_MASK = 32'h0000_ff7f;
  // keypad / serial command pulses
  localparam int KEY_RESET = 0;
  localparam int KEY_FWD   = 1;
  localparam int KEY_REV   = 2;
  localparam int KEY_STOP  = 3;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  // status fields
  localparam int ST_B_RUN   = 0;
  localparam int ST_B_REV   = 1;
  localparam int ST_B_TRIP  = 2;
  localparam int ST_B_WARN  = 3;
  localparam int ST_B_MAN   = 4;
  localparam int ST_B_RETRY = 5;
  localparam int ST_B_COAST = 6;
  localparam int ST_B_ATT   = 8;
  // terminal input positions
  localparam int IN_FWD  = 0;
  localparam int IN_STOP = 1;
  localparam int IN_AUX  = 2;
  localparam int IN_RST  = 3;
  localparam int NUM_IN  = 4;
  // function of the spare terminal input
  localparam logic [1:0] AUX_OFF = 2'h0;
  localparam logic [1:0] AUX_REV = 2'h1;
  localparam logic [1:0] AUX_EN  = 2'h2;
  typedef enum logic [1:0] {ST_STOP, ST_RUN, ST_TRIP} rsr_state_t;
endpackage

// ### verilog/rsr_sync.sv
// Purpose: two-stage synchroniser for the terminal inputs
// Assumes: inputs are asynchronous switch or PLC levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module rsr_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output wire logic [W-1:0] q
);
  // ==========================================================
  // per-bit double flop
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end
        else
        begin
          meta_reg <= d[i];
          sync_reg <= meta_reg;
        end
      end
      assign q[i] = sync_reg;
    end
  endgenerate
endmodule // rsr_sync

// ### verilog/rsr_ms_timer.sv
// Purpose: millisecond delay timer for automatic reset
// Assumes: start is a one-cycle pulse
// Notes:   a delay of zero ends one tick after start
`timescale 1ns/100ps
module rsr_ms_timer #(
  parameter int TICK = rsr_pkg::CYC_PER_MS
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic [15:0] ms_load,
  output wire logic        done
);
  logic [15:0] pre_reg;
  logic [15:0] ms_reg;
  logic        act_reg;
  logic        done_reg;
  // ==========================================================
  // prescaler to one millisecond, then count down
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_reg  <= 16'h0000;
      ms_reg   <= 16'h0000;
      act_reg  <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (abort)
        act_reg <= 1'b0;
      else if (start)
      begin
        act_reg <= 1'b1;
        pre_reg <= 16'h0000;
        ms_reg  <= ms_load;
      end
      else if (act_reg)
      begin
        if (pre_reg == 16'(TICK - 1))
        begin
          pre_reg <= 16'h0000;
          if (ms_reg == 16'h0000)
          begin
            act_reg  <= 1'b0;
            done_reg <= 1'b1; // delay over
          end
          else
            ms_reg <= ms_reg - 16'h0001;
        end
        else
          pre_reg <= pre_reg + 16'h0001;
      end
    end
  end
  assign done = done_reg;
endmodule // rsr_ms_timer

// ### verilog/rsr_top.sv
// Purpose: run/stop/enable/reset control with manual and automatic reset
// Assumes: alarm inputs come from protection logic on the same clock
// Notes:   terminal inputs are synchronised before use
//
// Overview of operation
// - after a trip, no restart until a reset clears the trip
// - warning indication clears itself once its condition is gone
// - for marked alarms a new start signal also resets the trip
// - optional relay flag while a trip waits for manual reset
// - level mode with run held high starts as the reset clears
// - autoreset clears eligible trips and retries; stays tripped when attempts run out
// - optional relay flag once autoreset attempts are exhausted
// - undervoltage delay starts when fault is gone, or at once if stopped
// - autoreset is off while commands come from keypad or serial
// - a rising reset input clears a trip
// - edge mode needs a fresh run edge after reset
// - edge mode: any transition of a run input activates it
// - edge mode run accepted only with enable and stop closed
// - the run input with the latest edge sets the direction
// - enable low forbids running and makes the motor coast
// - with no enable input assigned, enable counts as true
// - stop input low stops with the chosen stop method; not under local control, where the stop input is ignored
// - level mode: input active while high; start right after reset
// - level mode: both run inputs active means stop
// - default map: input 1 forward, 2 stop, 4 reset, edge mode
// - reset accepted by default from terminals and keypad
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/100ps
module rsr_top #(
  parameter int MS_CYCLES = rsr_pkg::CYC_PER_MS
) (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output wire logic [31:0]               prdata,
  output wire logic                      pready,
  output wire logic                      pslverr,
  input  wire logic [rsr_pkg::NUM_IN-1:0] terminal_input,
  input  wire logic                      alarm_trip,
  input  wire logic                      alarm_cond,
  input  wire logic                      alarm_warn,
  input  wire logic                      alarm_start_reset,
  input  wire logic                      alarm_auto_ok,
  input  wire logic                      alarm_undervolt,
  output wire logic                      run_forward_cmd,
  output wire logic                      run_reverse_cmd,
  output wire logic                      coast_stop,
  output wire logic                      warn_flag,
  output wire logic                      manual_clear_needed_flag,
  output wire logic                      retry_exhausted_flag
);
  logic [rsr_pkg::NUM_IN-1:0] sin;
  logic [rsr_pkg::NUM_IN-1:0] prev_reg;
  logic [31:0]                ctrl_reg;
  logic [15:0]                delay_reg;
  logic [3:0]                 key_reg;
  logic [31:0]                prdata_reg;
  logic                       pready_reg;
  logic                       pslverr_reg;
  rsr_pkg::rsr_state_t        state_reg;
  logic [3:0]                 att_reg;
  logic                       dir_reg;
  logic                       was_run_reg;
  logic                       clr_start_reg;
  logic                       auto_ok_reg;
  logic                       uv_reg;
  logic                       timing_reg;
  logic                       run_reg;
  logic                       rev_reg;
  logic                       coast_reg;
  logic                       warn_reg;
  logic                       man_reg;
  logic                       retry_reg;
  logic                       tmr_start;
  logic                       tmr_done;
  // ==========================================================
  // terminal inputs and command decode
  rsr_sync #(
    .W (rsr_pkg::NUM_IN)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (terminal_input),
    .q    (sin)
  );
  wire [1:0] aux_fn   = ctrl_reg[rsr_pkg::CTRL_AUX_LO +: 2];
  wire [3:0] max_att  = ctrl_reg[rsr_pkg::CTRL_MAX_LO +: 4];
  wire       lvl_mode = ctrl_reg[rsr_pkg::CTRL_LEVEL];
  wire       local_c  = ctrl_reg[rsr_pkg::CTRL_LOCAL];
  wire       fwd      = sin[rsr_pkg::IN_FWD];
  wire       rev      = (aux_fn == rsr_pkg::AUX_REV) & sin[rsr_pkg::IN_AUX];
  wire       stop_ok  = local_c | sin[rsr_pkg::IN_STOP];
  wire       enable   = (aux_fn != rsr_pkg::AUX_EN) | sin[rsr_pkg::IN_AUX];
  wire       fwd_tgl  = fwd ^ prev_reg[rsr_pkg::IN_FWD];
  wire       rev_tgl  = (aux_fn == rsr_pkg::AUX_REV) & (sin[rsr_pkg::IN_AUX] ^ prev_reg[rsr_pkg::IN_AUX]);
  // edge start needs enable and stop closed
  wire       edge_go  = !local_c & !lvl_mode & (fwd_tgl | rev_tgl) & enable & stop_ok;
  // level active while held; both high is no run
  wire       lvl_go   = !local_c & lvl_mode & (fwd ^ rev) & enable & stop_ok;
  wire       key_go   = local_c & (key_reg[rsr_pkg::KEY_FWD] | key_reg[rsr_pkg::KEY_REV]) & enable;
  wire       start    = edge_go | lvl_go | key_go;
  // latest edge wins, reverse if both at once
  wire       new_dir  = local_c ? key_reg[rsr_pkg::KEY_REV] : (lvl_mode ? rev : rev_tgl);
  wire       rst_rise = ctrl_reg[rsr_pkg::CTRL_SRC_TERM] & sin[rsr_pkg::IN_RST] & !prev_reg[rsr_pkg::IN_RST];
  wire       key_rst  = ctrl_reg[rsr_pkg::CTRL_SRC_KEY] & key_reg[rsr_pkg::KEY_RESET];
  wire       reset_c  = rst_rise | key_rst;
  // reset input held high arms autoreset; not under local control
  wire       ar_on    = sin[rsr_pkg::IN_RST] & !local_c & (max_att != 4'h0);
  wire       ar_left  = ar_on & auto_ok_reg & (att_reg < max_att);
  // local stop key under keypad control, level drop otherwise
  wire       stop_req = local_c ? key_reg[rsr_pkg::KEY_STOP] : (lvl_mode & !lvl_go);

  // edge history, updated every cycle so edges during a trip are consumed
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      prev_reg <= '0;
    else
      prev_reg <= sin;
  end

  // ==========================================================
  // APB slave, no wait states for reads and writes
  wire setup  = psel & !penable;
  wire access = psel & penable & pready_reg;
  wire mapped = (paddr == rsr_pkg::ADDR_CTRL) | (paddr == rsr_pkg::ADDR_KEY) |
                (paddr == rsr_pkg::ADDR_DELAY) | (paddr == rsr_pkg::ADDR_STATUS);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= setup;
      pslverr_reg <= setup & !mapped;
      if (setup & !pwrite)
      begin
        case (paddr)
          rsr_pkg::ADDR_CTRL:   prdata_reg <= ctrl_reg;
          rsr_pkg::ADDR_DELAY:  prdata_reg <= {16'h0000, delay_reg};
          rsr_pkg::ADDR_STATUS: prdata_reg <= {20'h00000, att_reg, 1'b0, coast_reg, retry_reg,
                                               man_reg, warn_reg, state_reg == rsr_pkg::ST_TRIP,
                                               rev_reg, run_reg};
          default:              prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // configuration, defaults edge mode and both reset sources
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg  <= rsr_pkg::CTRL_RST;
      delay_reg <= rsr_pkg::DELAY_RST;
      key_reg   <= 4'h0;
    end
    else
    begin
      key_reg <= 4'h0; // command pulses last one cycle
      if (access & pwrite)
      begin
        if (paddr == rsr_pkg::ADDR_CTRL)
          ctrl_reg <= pwdata & rsr_pkg::CTRL_MASK;
        if (paddr == rsr_pkg::ADDR_DELAY)
          delay_reg <= pwdata[15:0];
        if (paddr == rsr_pkg::ADDR_KEY)
          key_reg <= pwdata[3:0];
      end
    end
  end

  // ==========================================================
  // autoreset delay
  // undervoltage times from fault gone, or at once if stopped
  assign tmr_start = (state_reg == rsr_pkg::ST_TRIP) & ar_left & !timing_reg & !alarm_trip &
                     (!alarm_cond | (uv_reg & !was_run_reg));
  rsr_ms_timer #(
    .TICK (MS_CYCLES)
  ) u_tmr (
    .clk     (clk),
    .rstn    (rstn),
    .start   (tmr_start),
    .abort   (!ar_on | (state_reg != rsr_pkg::ST_TRIP)),
    .ms_load (delay_reg),
    .done    (tmr_done)
  );

  // ==========================================================
  // run / stop / trip sequencing
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg     <= rsr_pkg::ST_STOP;
      att_reg       <= 4'h0;
      dir_reg       <= 1'b0;
      was_run_reg   <= 1'b0;
      clr_start_reg <= 1'b0;
      auto_ok_reg   <= 1'b0;
      uv_reg        <= 1'b0;
      timing_reg    <= 1'b0;
      coast_reg     <= 1'b0;
    end
    else if (alarm_trip)
    begin
      // a new trip wins over any clear in the same cycle
      state_reg     <= rsr_pkg::ST_TRIP;
      was_run_reg   <= (state_reg == rsr_pkg::ST_RUN);
      clr_start_reg <= alarm_start_reset;
      auto_ok_reg   <= alarm_auto_ok;
      uv_reg        <= alarm_undervolt;
      timing_reg    <= 1'b0;
      coast_reg     <= 1'b1;
    end
    else
    begin
      case (state_reg)
        rsr_pkg::ST_STOP:
        begin
          // edge mode restarts only on a new run edge
          // level run held high starts as soon as the trip clears
          if (start)
          begin
            state_reg <= rsr_pkg::ST_RUN;
            dir_reg   <= new_dir;
            coast_reg <= 1'b0;
          end
        end
        rsr_pkg::ST_RUN:
        begin
          // enable low coasts; stop uses chosen method
          if (!enable)
          begin
            state_reg <= rsr_pkg::ST_STOP;
            coast_reg <= 1'b1;
          end
          else if (!stop_ok | stop_req)
          begin
            state_reg <= rsr_pkg::ST_STOP;
            coast_reg <= ctrl_reg[rsr_pkg::CTRL_COAST];
          end
          // direction follows the latest edge or the held level
          else if (edge_go | key_go | lvl_go)
            dir_reg <= new_dir;
        end
        rsr_pkg::ST_TRIP:
        begin
          if (tmr_start)
            timing_reg <= 1'b1;
          if (!ar_on)
            timing_reg <= 1'b0;
          // manual reset clears the trip and the attempt count
          if (reset_c)
          begin
            state_reg  <= rsr_pkg::ST_STOP;
            att_reg    <= 4'h0;
            timing_reg <= 1'b0;
          end
          // start signal acts as reset for marked alarms
          else if (clr_start_reg & start)
          begin
            state_reg <= rsr_pkg::ST_RUN;
            dir_reg   <= new_dir;
            coast_reg <= 1'b0;
          end
          // automatic reset, counted, retries a run that was active
          else if (tmr_done)
          begin
            att_reg    <= att_reg + 4'h1;
            timing_reg <= 1'b0;
            if (was_run_reg & enable & stop_ok)
            begin
              state_reg <= rsr_pkg::ST_RUN;
              coast_reg <= 1'b0;
            end
            else
              state_reg <= rsr_pkg::ST_STOP;
          end
        end
        default:
          state_reg <= rsr_pkg::ST_STOP;
      endcase
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      run_reg   <= 1'b0;
      rev_reg   <= 1'b0;
      warn_reg  <= 1'b0;
      man_reg   <= 1'b0;
      retry_reg <= 1'b0;
    end
    else
    begin
      run_reg  <= (state_reg == rsr_pkg::ST_RUN);
      rev_reg  <= dir_reg;
      // warning follows its condition, no reset needed
      warn_reg <= alarm_warn;
      // trip that autoreset will not clear
      man_reg  <= ctrl_reg[rsr_pkg::CTRL_RLY_MAN] & (state_reg == rsr_pkg::ST_TRIP) & !ar_left;
      retry_reg <= ctrl_reg[rsr_pkg::CTRL_RLY_RETRY] & (state_reg == rsr_pkg::ST_TRIP) & ar_on &
                   auto_ok_reg & (att_reg >= max_att);
    end
  end

  assign run_forward_cmd          = run_reg & !rev_reg;
  assign run_reverse_cmd          = run_reg & rev_reg;
  assign coast_stop               = coast_reg;
  assign warn_flag                = warn_reg;
  assign manual_clear_needed_flag = man_reg;
  assign retry_exhausted_flag     = retry_reg;
  assign prdata                   = prdata_reg;
  assign pready                   = pready_reg;
  assign pslverr                  = pslverr_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  trip_blocks_run_a: assert property ((state_reg == rsr_pkg::ST_TRIP) |=> !run_reg)
    else $error("motor ran while tripped");
  warn_clears_a: assert property (!alarm_warn ##1 !alarm_warn |-> !warn_flag)
    else $error("warning stayed without condition");
  manual_flag_a: assert property ((ctrl_reg[rsr_pkg::CTRL_RLY_MAN] && state_reg == rsr_pkg::ST_TRIP
    && !ar_left) |=> manual_clear_needed_flag)
    else $error("manual reset flag missing");
  local_no_auto_a: assert property (local_c |-> !tmr_start)
    else $error("autoreset timed under local control");
  term_reset_a: assert property ((state_reg == rsr_pkg::ST_TRIP && rst_rise && !alarm_trip)
    |=> state_reg == rsr_pkg::ST_STOP)
    else $error("reset edge did not clear trip");
  edge_no_restart_a: assert property ((state_reg == rsr_pkg::ST_STOP && !lvl_mode && !start)
    |=> state_reg != rsr_pkg::ST_RUN)
    else $error("edge mode restarted without edge");
  enable_coast_a: assert property ((state_reg == rsr_pkg::ST_RUN && !enable && !alarm_trip)
    |=> (state_reg == rsr_pkg::ST_STOP && coast_reg) ##1 !run_reg)
    else $error("enable low did not coast");
  both_run_stop_a: assert property ((lvl_mode && !local_c && fwd && rev && state_reg == rsr_pkg::ST_RUN)
    |=> state_reg != rsr_pkg::ST_RUN)
    else $error("both run inputs did not stop");
  attempt_count_a: assert property ((tmr_done && state_reg == rsr_pkg::ST_TRIP && !alarm_trip && !reset_c
    && !(clr_start_reg && start)) |=> att_reg == $past(att_reg) + 4'h1)
    else $error("attempt counter not advanced");
endmodule // rsr_top

// ### test/rsr_field_model.sv
// Purpose: switch / PLC side of the terminal strip
// Assumes: levels are set by the bench just after a rising edge
// Notes:   inputs are active high, stop and enable read high as closed
`timescale 1ns/100ps
module rsr_field_model (
  input  wire logic [3:0] lvl,
  output wire logic [3:0] terminal_input
);
  // ==========================================================
  // contacts
  // reset held high
  // stop wired, fresh edges
  // a contact follows its bench level directly; the bench may move more than one at a time
  assign terminal_input = lvl;
endmodule // rsr_field_model

// ### test/tb_rsr_top.sv
// Purpose: self-checking bench for the run/stop/reset control
// Assumes: MS_CYCLES of 4 shortens each millisecond
// Notes:   pin order is {reset, aux, stop, forward}
`timescale 1ns/100ps
module tb_rsr_top;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  lvl, terminal_input;
  logic        alarm_trip, alarm_cond, alarm_warn, alarm_start_reset, alarm_auto_ok, alarm_undervolt;
  logic        fwd, rev, coast, warn, man, retry;
  int          err_count, n_compared;
  logic [7:0]  row_addr [4] = '{8'h00, 8'h08, 8'h0c, 8'h10};
  logic [31:0] row_data [4] = '{32'h0000_0006, 32'h0, 32'h0, 32'h0};
  logic        row_err  [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

  // ==========================================================
  // instances
  rsr_field_model field (.lvl(lvl), .terminal_input(terminal_input));
  rsr_top #(.MS_CYCLES(4)) DUT (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .terminal_input(terminal_input),
    .alarm_trip(alarm_trip), .alarm_cond(alarm_cond), .alarm_warn(alarm_warn),
    .alarm_start_reset(alarm_start_reset), .alarm_auto_ok(alarm_auto_ok), .alarm_undervolt(alarm_undervolt),
    .run_forward_cmd(fwd), .run_reverse_cmd(rev), .coast_stop(coast), .warn_flag(warn),
    .manual_clear_needed_flag(man), .retry_exhausted_flag(retry));

  // ==========================================================
  // helpers
  task conclude;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_compared++;
      if (seen !== exp)
      begin
        err_count++;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // outputs {fwd, rev, coast, warn, manual, retry}; coast is left out here
  task co(input logic [5:0] e);
    chk({26'h0, fwd, rev, 1'b0, warn, man, retry}, {26'h0, e & 6'b110111});
  endtask
  // apb transfer: setup, then access until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
        @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task pins(input logic [3:0] v);
    begin
      @(posedge clk);
      lvl <= v;
      repeat (8) @(posedge clk);
    end
  endtask
  task trip(input logic sr, input logic ok);
    begin
      @(posedge clk);
      alarm_trip        <= 1'b1;
      alarm_start_reset <= sr;
      alarm_auto_ok     <= ok;
      @(posedge clk);
      alarm_trip <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  // ==========================================================
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    err_count = 0;
    n_compared = 0;
    {rstn, psel, penable, pwrite, paddr, pwdata, lvl} = '0;
    {alarm_trip, alarm_cond, alarm_warn, alarm_start_reset, alarm_auto_ok, alarm_undervolt} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, row_addr[i], 32'h0);
      chk(rd, row_data[i]);
      chk({31'h0, er}, {31'h0, row_err[i]});
    end
    co(6'b000000);
    apb(1'b1, 8'h00, 32'h0000_0016);
    pins(4'b0010);
    co(6'b000000);
    pins(4'b0011);
    co(6'b100000);
    pins(4'b0010);
    co(6'b100000);
    alarm_cond <= 1'b1;
    trip(1'b0, 1'b0);
    co(6'b000010);
    pins(4'b0011);
    co(6'b000010);
    alarm_cond <= 1'b0;
    pins(4'b1011);
    co(6'b000000);
    pins(4'b1010);
    co(6'b100000);
    pins(4'b1000);
    co(6'b000000);
    chk({31'h0, coast}, 32'h0);
    apb(1'b1, 8'h00, 32'h0000_0116);
    pins(4'b1010);
    pins(4'b1110);
    co(6'b010000);
    pins(4'b1111);
    co(6'b100000);
    apb(1'b1, 8'h00, 32'h0000_0216);
    pins(4'b1011);
    co(6'b000000);
    chk({31'h0, coast}, 32'h1);
    pins(4'b1010);
    co(6'b000000);
    apb(1'b1, 8'h00, 32'h0000_0016);
    pins(4'b1011);
    co(6'b100000);
    pins(4'b1001);
    apb(1'b1, 8'h00, 32'h0000_0117);
    pins(4'b1011);
    co(6'b100000);
    trip(1'b0, 1'b0);
    pins(4'b0011);
    co(6'b000010);
    pins(4'b1011);
    co(6'b100000);
    pins(4'b1111);
    co(6'b000000);
    pins(4'b1010);
    @(posedge clk);
    alarm_warn <= 1'b1;
    repeat (3) @(posedge clk);
    co(6'b000100);
    alarm_warn <= 1'b0;
    repeat (3) @(posedge clk);
    co(6'b000000);
    apb(1'b1, 8'h00, 32'h0000_0016);
    trip(1'b1, 1'b0);
    pins(4'b1011);
    co(6'b100000);
    apb(1'b1, 8'h00, 32'h0000_1036);
    trip(1'b0, 1'b1);
    repeat (20) @(posedge clk);
    co(6'b100000);
    apb(1'b0, 8'h0c, 32'h0);
    chk({28'h0, rd[11:8]}, 32'h1);
    trip(1'b0, 1'b1);
    repeat (20) @(posedge clk);
    co(6'b000011);
    apb(1'b1, 8'h04, 32'h0000_0001);
    repeat (4) @(posedge clk);
    co(6'b000000);
    apb(1'b1, 8'h00, 32'h0000_103e);
    apb(1'b1, 8'h04, 32'h0000_0002);
    repeat (4) @(posedge clk);
    co(6'b100000);
    trip(1'b0, 1'b1);
    repeat (20) @(posedge clk);
    co(6'b000010);
    // undervoltage trip while stopped times at once, while running waits for the fault to go
    apb(1'b1, 8'h04, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_2036);
    alarm_cond      <= 1'b1;
    alarm_undervolt <= 1'b1;
    trip(1'b0, 1'b1);
    repeat (20) @(posedge clk);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd & 32'h0000_0f05, 32'h0000_0100);
    pins(4'b1010);
    trip(1'b0, 1'b1);
    repeat (20) @(posedge clk);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd & 32'h0000_0f05, 32'h0000_0104);
    alarm_cond <= 1'b0;
    repeat (20) @(posedge clk);
    co(6'b100000);
    apb(1'b0, 8'h0c, 32'h0);
    chk({28'h0, rd[11:8]}, 32'h2);
    // reset in mid-run clears outputs and restores the defaults
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    co(6'b000000);
    chk({31'h0, coast}, 32'h0);
    rstn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_0006);
    conclude();
  end
endmodule // tb_rsr_top
